// file: verilog/tobc_device.sv
// Purpose: device end, bus slave with register file and band search
// Assumes: link_clk oversamples the bus lines, clk is the core clock
// Notes:   register writes cross to the core by toggles and level syncs
// Operation
// - Host programs corner code by formula
// - Twenty-four bands, manual band reported back
// - Auto enable makes device pick band
// - Low fractional word write starts search
// - Host writes low fractional word last
// - Search starts from programmed band field
// - Done flag stays clear while searching
// - Success sets done, success, reports band
// - Failure sets done, clears success
// - Level code meaning: out, locked, search-locked
// - Search accepts only search-locked levels
// - Host sets level sense enable first
// - Latch write captures level into status
// - Standby shuts path, bus stays alive
// - Registers retained through standby
// - Host writes all registers after 100us
// - Slave access with auto-incrementing pointer
`include "tobc_defs.svh"
module tobc_device
  import tobc_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = `TOBC_SETTLE_CYC
)
(
  input  wire logic       clk,
  input  wire logic       link_clk,
  input  wire logic       reset_n,
  tobc_i2c_if.dev         bus,
  input  wire logic [2:0] tune_voltage_node,
  output logic [4:0]      osc_band_sel,
  output logic            path_enable,
  output logic            search_busy,
  output logic [7:0]      corner_code,
  output logic [7:0]      int_divider,
  output logic [15:0]     frac_divider
);
  tobc_link_t lk, ln;
  tobc_core_t ck, cn;

  // ------------------------------------------------------------------
  // Read mux of the register space
  // ------------------------------------------------------------------
  function automatic logic [7:0] rd_byte(input tobc_link_t l);
    logic [7:0] v;
    v = `TOBC_RST_BYTE;
    if (l.ptr < 8'(`TOBC_NUM_WREG))
      v = l.regs[l.ptr[3:0]];
    else if (l.ptr == `TOBC_REG_STAT1)
      v = {`TOBC_STAT1_PAD, l.stat[9:8]};
    else if (l.ptr == `TOBC_REG_STAT2)
      v = l.stat[7:0];
    return v;
  endfunction

  // ------------------------------------------------------------------
  // Link domain: bus slave and register file
  // ------------------------------------------------------------------
  // Next state of the link side, one pass per link clock
  always_comb
  begin
    logic rise;
    logic fall;
    logic sstart;
    logic sstop;
    logic [7:0] rb;
    ln = lk;
    ln.rst_s1 = reset_n;
    ln.rst_s2 = lk.rst_s1;
    ln.scl_s1 = bus.scl;
    ln.scl_s2 = lk.scl_s1;
    ln.scl_s3 = lk.scl_s2;
    ln.sda_s1 = bus.sda;
    ln.sda_s2 = lk.sda_s1;
    ln.sda_s3 = lk.sda_s2;
    // Only settled line levels count, which rejects single glitches
    if (lk.scl_s2 == lk.scl_s3)
      ln.scl_f = lk.scl_s3;
    if (lk.sda_s2 == lk.sda_s3)
      ln.sda_f = lk.sda_s3;
    ln.st_s1 = ck.snap_tgl;
    ln.st_s2 = lk.st_s1;
    ln.st_s3 = lk.st_s2;
    // Core status is stable when its toggle arrives
    if (lk.st_s2 != lk.st_s3)
      ln.stat = {ck.done, ck.succ, ck.band_cur, ck.lvl_cap};
    rise = ln.scl_f & ~lk.scl_f;
    fall = ~ln.scl_f & lk.scl_f;
    sstart = lk.scl_f & ln.scl_f & lk.sda_f & ~ln.sda_f;
    sstop = lk.scl_f & ln.scl_f & ~lk.sda_f & ln.sda_f;
    rb = rd_byte(lk);
    if (!lk.rst_s2)
    begin
      ln.scl_f = 1'b1;
      ln.sda_f = 1'b1;
      ln.st = SL_IDLE;
      ln.bitcnt = 4'h0;
      ln.shreg = `TOBC_RST_BYTE;
      ln.ptr = `TOBC_RST_BYTE;
      ln.sda_oe = 1'b0;
      ln.regs = '0;
      ln.start_tgl = 1'b0;
      ln.latch_tgl = 1'b0;
      ln.stat = '0;
    end
    else if (sstart)
    begin
      ln.st = SL_DEV;
      ln.bitcnt = `TOBC_PRE_BIT;
      ln.sda_oe = 1'b0;
    end
    else if (sstop)
    begin
      ln.st = SL_IDLE;
      ln.sda_oe = 1'b0;
    end
    else if (lk.st != SL_IDLE)
    begin
      // Sample on the rising clock edge, MSB first
      if (rise)
      begin
        if (lk.bitcnt < `TOBC_ACK_BIT && lk.st != SL_RD)
          ln.shreg = {lk.shreg[6:0], ln.sda_f};
        // Host NACK after a read byte ends the burst
        if (lk.bitcnt == `TOBC_ACK_BIT && lk.st == SL_RD && ln.sda_f)
          ln.st = SL_IDLE;
      end
      // Drive on the falling clock edge
      if (fall)
      begin
        // The clock fall that closes a start is not a bit
        if (lk.bitcnt == `TOBC_PRE_BIT)
          ln.bitcnt = 4'h0;
        else if (lk.bitcnt < `TOBC_LAST_BIT)
        begin
          ln.bitcnt = lk.bitcnt + 4'h1;
          if (lk.st == SL_RD)
          begin
            ln.shreg = {lk.shreg[6:0], 1'b0};
            ln.sda_oe = ~lk.shreg[6];
          end
        end
        else if (lk.bitcnt == `TOBC_LAST_BIT)
        begin
          ln.bitcnt = `TOBC_ACK_BIT;
          ln.sda_oe = 1'b1;
          case (lk.st)
            SL_DEV:
            begin
              if (lk.shreg[7:1] != `TOBC_SLV_ADDR)
              begin
                ln.st = SL_IDLE;
                ln.sda_oe = 1'b0;
              end
            end
            SL_REG:
              ln.ptr = lk.shreg;
            SL_WR:
            begin
              if (lk.ptr < 8'(`TOBC_NUM_WREG))
                ln.regs[lk.ptr[3:0]] = lk.shreg;
              if (lk.ptr == `TOBC_REG_FRACL && lk.regs[`TOBC_REG_BAND][`TOBC_AUTO_BIT])
                ln.start_tgl = ~lk.start_tgl;
              if (lk.ptr == `TOBC_REG_BAND && lk.shreg[`TOBC_LATCH_BIT])
                ln.latch_tgl = ~lk.latch_tgl;
              ln.ptr = lk.ptr + 8'h01;
            end
            SL_RD:
              ln.sda_oe = 1'b0;
            default:
              ln.st = SL_IDLE;
          endcase
        end
        else
        begin
          ln.bitcnt = 4'h0;
          ln.sda_oe = 1'b0;
          case (lk.st)
            SL_DEV:
              ln.st = lk.shreg[0] ? SL_RD : SL_REG;
            SL_REG:
              ln.st = SL_WR;
            default:
              ln.st = lk.st;
          endcase
          if (lk.st == SL_RD || (lk.st == SL_DEV && lk.shreg[0]))
          begin
            ln.shreg = rb;
            ln.sda_oe = ~rb[7];
            ln.ptr = lk.ptr + 8'h01;
          end
        end
      end
    end
  end

  // Link register bank
  always_ff @(posedge link_clk)
    lk <= ln;

  // ------------------------------------------------------------------
  // Core domain: band selection, search and level capture
  // ------------------------------------------------------------------
  // Next state of the core side
  always_comb
  begin
    logic start_ev;
    logic latch_ev;
    logic sl_ok;
    cn = ck;
    cn.band_s1 = lk.regs[`TOBC_REG_BAND][`TOBC_BAND_MSB:`TOBC_BAND_LSB];
    cn.band_s2 = ck.band_s1;
    cn.auto_s1 = lk.regs[`TOBC_REG_BAND][`TOBC_AUTO_BIT];
    cn.auto_s2 = ck.auto_s1;
    cn.lsen_s1 = lk.regs[`TOBC_REG_BAND][`TOBC_LSEN_BIT];
    cn.lsen_s2 = ck.lsen_s1;
    cn.hold_s1 = lk.regs[`TOBC_REG_CTRL][`TOBC_HOLD_BIT];
    cn.hold_s2 = ck.hold_s1;
    cn.start_s1 = lk.start_tgl;
    cn.start_s2 = ck.start_s1;
    cn.start_s3 = ck.start_s2;
    cn.latch_s1 = lk.latch_tgl;
    cn.latch_s2 = ck.latch_s1;
    cn.latch_s3 = ck.latch_s2;
    cn.lvl_s1 = tune_voltage_node;
    cn.lvl_s2 = ck.lvl_s1;
    cn.lvl_s3 = ck.lvl_s2;
    // Analog comparator outputs settle before they count
    if (ck.lvl_s2 == ck.lvl_s3)
      cn.lvl_f = ck.lvl_s3;
    start_ev = ck.start_s2 != ck.start_s3;
    latch_ev = ck.latch_s2 != ck.latch_s3;
    sl_ok = ck.lvl_f == `TOBC_LVL_SL_A || ck.lvl_f == `TOBC_LVL_SL_B;
    if (!reset_n)
    begin
      cn.lvl_f = 3'h0;
      cn.st = SR_IDLE;
      cn.band_cur = 5'h00;
      cn.tries = 5'h00;
      cn.settle = 8'h00;
      cn.done = 1'b0;
      cn.succ = 1'b0;
      cn.busy = 1'b0;
      cn.path_en = 1'b0;
      cn.snap_tgl = 1'b0;
      cn.lvl_cap = 3'h0;
    end
    else
    begin
      cn.path_en = ~ck.hold_s2;
      if (latch_ev && ck.lsen_s2)
        cn.lvl_cap = ck.lvl_f;
      if (start_ev && ck.auto_s2)
      begin
        cn.st = SR_SETTLE;
        cn.band_cur = ck.band_s2;
        cn.tries = 5'h00;
        cn.settle = 8'h00;
        cn.done = 1'b0;
        cn.succ = 1'b0;
      end
      else
      begin
        case (ck.st)
          SR_IDLE:
          begin
            if (!ck.auto_s2)
              cn.band_cur = ck.band_s2;
          end
          SR_SETTLE:
          begin
            // Search freezes in standby, the oscillator is off then
            if (!ck.hold_s2)
            begin
              if (ck.settle == 8'(SETTLE_CYC - 1))
                cn.st = SR_CHECK;
              else
                cn.settle = ck.settle + 8'h01;
            end
          end
          SR_CHECK:
          begin
            if (sl_ok)
            begin
              cn.st = SR_IDLE;
              cn.done = 1'b1;
              cn.succ = 1'b1;
            end
            else if (ck.tries == `TOBC_LAST_BAND)
            begin
              cn.st = SR_IDLE;
              cn.done = 1'b1;
              cn.succ = 1'b0;
              cn.band_cur = ck.band_s2;
            end
            else
            begin
              cn.st = SR_SETTLE;
              cn.settle = 8'h00;
              cn.tries = ck.tries + 5'h01;
              cn.band_cur = (ck.band_cur == `TOBC_LAST_BAND) ? 5'h00 :
                            ck.band_cur + 5'h01;
            end
          end
          default:
            cn.st = SR_IDLE;
        endcase
      end
      cn.busy = cn.st != SR_IDLE;
      // Tell the link side the status snapshot changed
      if ({cn.done, cn.succ, cn.band_cur, cn.lvl_cap} !=
          {ck.done, ck.succ, ck.band_cur, ck.lvl_cap})
        cn.snap_tgl = ~ck.snap_tgl;
    end
  end

  // Core register bank
  always_ff @(posedge clk)
    ck <= cn;

  // ------------------------------------------------------------------
  // Outputs, straight from state flops except the data drive level, tied low
  // ------------------------------------------------------------------
  // corner code to filter
  assign corner_code = lk.regs[`TOBC_REG_CORNER];
  assign int_divider = lk.regs[`TOBC_REG_INTDIV];
  assign frac_divider = {lk.regs[`TOBC_REG_FRACH], lk.regs[`TOBC_REG_FRACL]};
  assign osc_band_sel = ck.band_cur;
  assign path_enable = ck.path_en;
  assign search_busy = ck.busy;
  assign bus.dev_sda_o = 1'b0; // Open drain, only ever pulls low
  assign bus.dev_sda_oe = lk.sda_oe;
endmodule

// file: verilog/tobc_defs.svh
// Purpose: named constants of the tuner band control link and core
// Assumes: 25 MHz core clock, 7-bit slave address on the two-wire bus
// Notes:   register file is byte wide, one byte per register address
`ifndef TOBC_DEFS_SVH
`define TOBC_DEFS_SVH
// --------------------------------------------------------------------
// Bus addressing
// --------------------------------------------------------------------
`define TOBC_SLV_ADDR    7'h60
`define TOBC_REG_INTDIV  8'h00
`define TOBC_REG_FRACH   8'h04
`define TOBC_REG_FRACL   8'h05
`define TOBC_REG_BAND    8'h06
`define TOBC_REG_CORNER  8'h07
`define TOBC_REG_CTRL    8'h08
`define TOBC_REG_STAT1   8'h0c
`define TOBC_REG_STAT2   8'h0d
`define TOBC_NUM_WREG    9
`define TOBC_RST_BYTE    8'h00
// --------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------
`define TOBC_BAND_MSB    7
`define TOBC_BAND_LSB    3
`define TOBC_AUTO_BIT    2
`define TOBC_LSEN_BIT    1
`define TOBC_LATCH_BIT   0
`define TOBC_HOLD_BIT    7
`define TOBC_STAT1_PAD   6'h00
// --------------------------------------------------------------------
// Bands, levels, bit counts
// --------------------------------------------------------------------
`define TOBC_LAST_BAND   5'h17
`define TOBC_LVL_SL_A    3'h2
`define TOBC_LVL_SL_B    3'h5
`define TOBC_LAST_BIT    4'h7
`define TOBC_ACK_BIT     4'h8
`define TOBC_PRE_BIT     4'hf
// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define TOBC_CLK_MHZ     25
`define TOBC_SCL_KHZ     400
`define TOBC_PWRUP_US    100
`define TOBC_PWRUP_CYC   (`TOBC_PWRUP_US * `TOBC_CLK_MHZ)
`define TOBC_SCL_QTR     ((`TOBC_CLK_MHZ * 1000 + 4 * `TOBC_SCL_KHZ - 1) / (4 * `TOBC_SCL_KHZ))
`define TOBC_SETTLE_CYC  8
`endif

// file: verilog/tobc_pkg.sv
// Purpose: types shared by both ends of the band control link
// Assumes: constants come from tobc_defs.svh
// Notes:   each clock domain keeps all its state in one struct from here
`include "tobc_defs.svh"
package tobc_pkg;
  // ------------------------------------------------------------------
  // State encodings
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    SL_IDLE = 5'h01,
    SL_DEV  = 5'h02,
    SL_REG  = 5'h04,
    SL_WR   = 5'h08,
    SL_RD   = 5'h10
  } tobc_slv_t;
  typedef enum logic [2:0] {
    SR_IDLE   = 3'h1,
    SR_SETTLE = 3'h2,
    SR_CHECK  = 3'h4
  } tobc_srch_t;
  typedef enum logic [2:0] {
    HM_WAIT = 3'h1,
    HM_IDLE = 3'h2,
    HM_RUN  = 3'h4
  } tobc_hst_t;
  typedef enum logic [1:0] {
    K_START = 2'h0,
    K_TX    = 2'h1,
    K_RX    = 2'h2,
    K_STOP  = 2'h3
  } tobc_kind_t;
  // ------------------------------------------------------------------
  // State records
  // ------------------------------------------------------------------
  typedef struct packed {
    logic                             rst_s1, rst_s2;
    logic                             scl_s1, scl_s2, scl_s3, scl_f;
    logic                             sda_s1, sda_s2, sda_s3, sda_f;
    tobc_slv_t                        st;
    logic [3:0]                       bitcnt;
    logic [7:0]                       shreg;
    logic [7:0]                       ptr;
    logic                             sda_oe;
    logic [`TOBC_NUM_WREG-1:0][7:0]   regs;
    logic                             start_tgl, latch_tgl;
    logic                             st_s1, st_s2, st_s3;
    logic [9:0]                       stat;
  } tobc_link_t;
  typedef struct packed {
    logic [4:0]  band_s1, band_s2;
    logic        auto_s1, auto_s2, lsen_s1, lsen_s2, hold_s1, hold_s2;
    logic        start_s1, start_s2, start_s3;
    logic        latch_s1, latch_s2, latch_s3;
    logic [2:0]  lvl_s1, lvl_s2, lvl_s3, lvl_f;
    tobc_srch_t  st;
    logic [4:0]  band_cur, tries;
    logic [7:0]  settle;
    logic        done, succ, busy, path_en, snap_tgl;
    logic [2:0]  lvl_cap;
  } tobc_core_t;
  typedef struct packed {
    tobc_hst_t   st;
    logic [11:0] pw;
    logic [4:0]  qcnt;
    logic [1:0]  phase;
    logic [3:0]  bitn;
    logic [2:0]  step;
    logic        rd;
    logic [7:0]  addr, wdata, sh, rdata;
    logic        nack, sda_s1, sda_s2, sda_s3, sda_f;
    logic        scl_oe, sda_oe, ready, rvalid;
  } tobc_host_t;
endpackage

// file: verilog/tobc_i2c_if.sv
// Purpose: open-drain two-wire link between host end and device end
// Assumes: every driver only ever pulls low when its enable is high
// Notes:   the wire levels are resolved here, pull-ups are implied
interface tobc_i2c_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Wired-and resolution of the pulled-up lines
  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                input scl, sda);
  modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// file: verilog/tobc_host.sv
// Purpose: host end, two-wire master doing single register accesses
// Assumes: no clock stretching, one byte per command
// Notes:   the bus clock is made here by a divider of clk
`include "tobc_defs.svh"
module tobc_host
  import tobc_pkg::*;
#(
  parameter int unsigned QTR       = `TOBC_SCL_QTR,
  parameter int unsigned PWRUP_CYC = `TOBC_PWRUP_CYC
)
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  tobc_i2c_if.host        bus,
  input  wire logic       cmd_valid,
  input  wire logic       cmd_read,
  input  wire logic [7:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready,
  output logic            rsp_valid,
  output logic [7:0]      rsp_rdata,
  output logic            rsp_nack
);
  tobc_host_t h, hn;

  // ------------------------------------------------------------------
  // Transfer scripts
  // ------------------------------------------------------------------
  function automatic tobc_kind_t kind_of(input logic rd, input logic [2:0] s);
    tobc_kind_t k;
    k = K_STOP;
    if (s == 3'h0 || (rd && s == 3'h3))
      k = K_START;
    else if (rd && s == 3'h5)
      k = K_RX;
    else if (s < (rd ? 3'h6 : 3'h4))
      k = K_TX;
    return k;
  endfunction

  function automatic logic [7:0] tx_byte(input tobc_host_t c, input logic [2:0] s);
    logic [7:0] b;
    b = `TOBC_RST_BYTE;
    case (s)
      3'h1: b = {`TOBC_SLV_ADDR, 1'b0};
      3'h2: b = c.addr;
      3'h3: b = c.wdata;
      3'h4: b = {`TOBC_SLV_ADDR, 1'b1};
      default: b = `TOBC_RST_BYTE;
    endcase
    return b;
  endfunction

  // ------------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------------
  // Quarter-period steps: drive data, raise clock, sample, lower clock
  always_comb
  begin
    logic tick;
    tobc_kind_t k;
    hn = h;
    hn.rvalid = 1'b0;
    hn.sda_s1 = bus.sda;
    hn.sda_s2 = h.sda_s1;
    hn.sda_s3 = h.sda_s2;
    if (h.sda_s2 == h.sda_s3)
      hn.sda_f = h.sda_s3;
    tick = h.qcnt == 5'(QTR - 1);
    hn.qcnt = tick ? 5'h00 : h.qcnt + 5'h01;
    k = kind_of(h.rd, h.step);
    if (!reset_n)
    begin
      hn.st = HM_WAIT;
      hn.pw = 12'h000;
      hn.qcnt = 5'h00;
      hn.sda_f = 1'b1;
      hn.scl_oe = 1'b0;
      hn.sda_oe = 1'b0;
      hn.ready = 1'b0;
      hn.nack = 1'b0;
      hn.rdata = `TOBC_RST_BYTE;
    end
    else
    begin
      case (h.st)
        HM_WAIT:
        begin
          if (h.pw == 12'(PWRUP_CYC - 1))
          begin
            hn.st = HM_IDLE;
            hn.ready = 1'b1;
          end
          else
            hn.pw = h.pw + 12'h001;
        end
        HM_IDLE:
        begin
          hn.qcnt = 5'h00;
          if (cmd_valid)
          begin
            hn.st = HM_RUN;
            hn.rd = cmd_read;
            hn.addr = cmd_addr;
            hn.wdata = cmd_wdata;
            hn.step = 3'h0;
            hn.bitn = 4'h0;
            hn.phase = 2'h0;
            hn.nack = 1'b0;
            hn.ready = 1'b0;
          end
        end
        HM_RUN:
        begin
          if (tick)
          begin
            hn.phase = h.phase + 2'h1;
            case (h.phase)
              2'h0:
              begin
                hn.scl_oe = 1'b1;
                hn.sda_oe = (k == K_STOP) ||
                            (k == K_TX && h.bitn < `TOBC_ACK_BIT && !h.sh[7]);
              end
              2'h1:
                hn.scl_oe = 1'b0;
              2'h2:
              begin
                if (k == K_START)
                  hn.sda_oe = 1'b1;
                else if (k == K_STOP)
                  hn.sda_oe = 1'b0;
                else if (k == K_TX && h.bitn == `TOBC_ACK_BIT)
                  hn.nack = h.nack | h.sda_f;
                else if (k == K_RX && h.bitn < `TOBC_ACK_BIT)
                  hn.sh = {h.sh[6:0], h.sda_f};
              end
              default:
              begin
                if (k != K_STOP)
                  hn.scl_oe = 1'b1;
                if ((k == K_TX || k == K_RX) && h.bitn < `TOBC_ACK_BIT)
                begin
                  hn.bitn = h.bitn + 4'h1;
                  if (k == K_TX)
                    hn.sh = {h.sh[6:0], 1'b0};
                end
                else
                begin
                  hn.bitn = 4'h0;
                  if (k == K_RX)
                    hn.rdata = h.sh;
                  if (k == K_STOP)
                  begin
                    hn.st = HM_IDLE;
                    hn.ready = 1'b1;
                    hn.rvalid = 1'b1;
                  end
                  else
                  begin
                    hn.step = h.step + 3'h1;
                    hn.sh = tx_byte(h, h.step + 3'h1);
                  end
                end
              end
            endcase
          end
        end
        default:
          hn.st = HM_WAIT;
      endcase
    end
  end

  // Host register bank
  always_ff @(posedge clk)
    h <= hn;

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign cmd_ready = h.ready;
  assign rsp_valid = h.rvalid;
  assign rsp_rdata = h.rdata;
  assign rsp_nack = h.nack;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_scl_oe = h.scl_oe;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = h.sda_oe;
endmodule

// file: sim/tobc_monitor.sv
// Purpose: wire checks on the two-wire link between both ends
// Assumes: bench quarter of 4 clk, so one bus clock phase is 8 clk
// Notes:   slave side is async, so its timing is bounded loosely
module tobc_monitor
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Open drain, nobody drives a high level
  property p_od; !host_scl_o && !host_sda_o && !dev_sda_o; endproperty
  a_od: assert property (p_od) else $error("line driven high");
  property p_hi; $rose(scl) |-> scl[*8]; endproperty
  a_hi: assert property (p_hi) else $error("clock high too short");
  property p_lo; $fell(scl) |-> !scl[*3] ##[1:6] scl; endproperty
  a_lo: assert property (p_lo) else $error("clock low wrong length");
  // Slave moving data with clock high would fake a start or stop
  property p_dchg; $changed(dev_sda_oe) |-> !scl; endproperty
  a_dchg: assert property (p_dchg) else $error("slave data moved, clock high");
  property p_dhold; $rose(scl) && dev_sda_oe |-> dev_sda_oe[*8]; endproperty
  a_dhold: assert property (p_dhold) else $error("slave bit not held");
  property p_dlen; $rose(dev_sda_oe) |-> ##[1:200] !dev_sda_oe; endproperty
  a_dlen: assert property (p_dlen) else $error("slave holds data line");
  // Both may pull low around an ack, but only while the clock is low
  property p_cont; host_sda_oe && dev_sda_oe |-> !scl; endproperty
  a_cont: assert property (p_cont) else $error("both ends drive data");
  property p_pwr; $rose(reset_n) |-> !host_scl_oe[*8]; endproperty
  a_pwr: assert property (p_pwr) else $error("bus used during power-up");
endmodule

// file: sim/tuner_oscillator_band_control_tb.sv
// Purpose: self-checking bench of host end and device end together
// Assumes: quarter 4, power-up wait 20, settle 250 core cycles
// Notes:   tune level is modelled from the band the device drives
module tuner_oscillator_band_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, link_clk = 1'b0, reset_n = 1'b0;
  logic       cmd_valid = 1'b0, cmd_read = 1'b0;
  logic [7:0] cmd_addr = 8'h00, cmd_wdata = 8'h00;
  logic [2:0] tune = 3'h0;
  logic [4:0] tgt = 5'h1f;
  logic       cmd_ready, rsp_valid, rsp_nack, path_enable, search_busy;
  logic [7:0] rsp_rdata, corner_code, q, int_div;
  logic [15:0] frac;
  logic [4:0] osc_band_sel;
  int         fail_count = 0, checks_done = 0;
  tobc_i2c_if bus_if();
  tobc_host #(.QTR(4), .PWRUP_CYC(20)) u_tobc_host (.clk(clk), .reset_n(reset_n),
    .bus(bus_if.host), .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .rsp_nack(rsp_nack));
  tobc_device #(.SETTLE_CYC(250)) u_tobc_device (.clk(clk), .link_clk(link_clk),
    .reset_n(reset_n), .bus(bus_if.dev), .tune_voltage_node(tune),
    .osc_band_sel(osc_band_sel), .path_enable(path_enable), .search_busy(search_busy),
    .corner_code(corner_code), .int_divider(int_div), .frac_divider(frac));
  tobc_monitor u_tobc_monitor (.clk(clk), .reset_n(reset_n),
    .host_scl_o(bus_if.host_scl_o), .host_scl_oe(bus_if.host_scl_oe),
    .host_sda_o(bus_if.host_sda_o), .host_sda_oe(bus_if.host_sda_oe),
    .dev_sda_o(bus_if.dev_sda_o), .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl));
  always #20 clk = ~clk;
  initial #1.7 forever #3 link_clk = ~link_clk;
  // Band below target reads locked only, so the search must pass it by
  always @(posedge clk) tune <= (osc_band_sel === tgt) ? 3'h5 :
                               (osc_band_sel === tgt - 5'h01) ? 3'h1 : 3'h0;
  task automatic summarize;
    if (fail_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One register access, offered for one clock once the host is ready, then its response awaited
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    while (cmd_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    while (rsp_valid !== 1'b1) @(negedge clk);
    q = rsp_rdata;
    chk({7'h00, rsp_nack}, 8'h00);
  endtask
  task automatic srch;
    while (search_busy !== 1'b0) @(negedge clk);
  endtask
  initial
  begin
    #3ms;
    fail_count++;
    summarize;
  end
  initial
  begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    acc(0, 8'h07, 8'h2a);
    acc(1, 8'h07, 8'h00);
    chk(q, 8'h2a);
    chk(corner_code, 8'h2a);
    acc(0, 8'h00, 8'h5a);
    chk(int_div, 8'h5a);
    acc(0, 8'h06, 8'h48);
    acc(1, 8'h0d, 8'h00);
    chk(q >> 3, 8'h09);
    acc(1, 8'h20, 8'h00);
    chk(q, 8'h00);
    acc(0, 8'h06, 8'h54);
    acc(0, 8'h05, 8'h11);
    srch;
    acc(1, 8'h0c, 8'h00);
    chk(q, 8'h02);
    acc(1, 8'h0d, 8'h00);
    chk(q >> 3, 8'h0a);
    tgt = 5'h0c;
    acc(0, 8'h04, 8'h12);
    acc(0, 8'h05, 8'h33);
    chk({7'h00, search_busy}, 8'h01);
    chk(frac[15:8], 8'h12);
    chk(frac[7:0], 8'h33);
    acc(1, 8'h0c, 8'h00);
    chk(q, 8'h00);
    srch;
    acc(1, 8'h0c, 8'h00);
    chk(q, 8'h03);
    chk({3'h0, osc_band_sel}, 8'h0c);
    acc(0, 8'h06, 8'h62);
    acc(0, 8'h06, 8'h63);
    acc(1, 8'h0d, 8'h00);
    chk(q, 8'h65);
    acc(0, 8'h08, 8'h80);
    chk({7'h00, path_enable}, 8'h00);
    acc(1, 8'h07, 8'h00);
    chk(q, 8'h2a);
    acc(0, 8'h08, 8'h00);
    chk({7'h00, path_enable}, 8'h01);
    summarize;
  end
endmodule
